// ==== rtl/timer_ctrl_map.vh ====
// constants for the timer mode and control register block
// assumes byte addresses are four times the register index
`ifndef TIMER_CTRL_MAP_VH
`define TIMER_CTRL_MAP_VH
// ==========================================
// register indices (byte address = index * 4)
`define IDX_RUN_CTRL 6'h00
`define IDX_MODE_CTRL 6'h01
`define IDX_OUT_FORCE 6'h02
`define IDX_SPLIT_SEL 6'h03
`define IDX_E_CLR 6'h04
`define IDX_E_SET 6'h05
`define IDX_F_CLR 6'h06
`define IDX_F_SET 6'h07
`define IDX_CYC_LEN 6'h26
`define IDX_CH0 6'h28
`define IDX_CH1 6'h2A
`define IDX_CH2 6'h2C
`define IDX_CYC_BUF 6'h36
`define IDX_CH0_BUF 6'h38
`define IDX_CH1_BUF 6'h3A
`define IDX_CH2_BUF 6'h3C
// ==========================================
// field positions
`define RUN_EN_BIT 0
`define MODE_LSB 0
`define MODE_MSB 2
`define AUTO_HOLD_BIT 3
`define PIN_EN_LSB 4
`define PIN_EN_MSB 6
`define E_DIR_BIT 0
`define E_HOLD_BIT 1
`define E_CMD_LSB 2
`define E_CMD_MSB 3
// ==========================================
// waveform mode codes
`define WM_NORMAL 3'h0
`define WM_FREQ 3'h1
`define WM_ONE_RAMP 3'h3
`define WM_TWO_HIGH 3'h5
`define WM_TWO_BOTH 3'h6
`define WM_TWO_LOW 3'h7
// command codes
`define CMD_NONE 2'h0
`define CMD_UPDATE 2'h1
`define CMD_RESTART 2'h2
`define CMD_HARD_RESET 2'h3
// ==========================================
// reset values
`define RST_BYTE 8'h00
`define RST_CYC_LEN 16'hFFFF
`define RST_CH 16'h0000
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== rtl/timer_mode_control_regs.v ====
// timer mode, command, hold, direction and buffer-valid control with AXI4-Lite registers
// assumes the counter outside gives top and bottom pulses on sys_clk
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "timer_ctrl_map.vh"
`default_nettype none
module timer_mode_control_regs (
  input wire sys_clk, // 50 MHz clock
  input wire resetn, // synchronous reset, active low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output wire [1:0] s_axi_bresp, // write response
  output wire s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output wire [31:0] s_axi_rdata, // read data
  output wire [1:0] s_axi_rresp, // read response
  output wire s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire top_hit, // counter reached top, pulse
  input wire bottom_hit, // counter reached bottom, pulse
  input wire hw_dir_load, // hardware direction load, pulse
  input wire hw_dir_value, // hardware direction value
  input wire [2:0] wave_level_in, // generator output levels
  output wire timer_enable, // timer run enable
  output wire [2:0] waveform_mode_field, // active mode code
  output wire top_from_channel0, // top comes from channel zero
  output wire split_select_bit, // two eight-bit timers
  output wire count_down, // counting direction
  output wire buffer_load_hold, // lock state
  output wire [3:0] buffer_valid, // valid bits, bit0 cycle length
  output wire [15:0] cycle_length_out, // active cycle length
  output wire [15:0] ch0_match, // active channel 0 compare
  output wire [15:0] ch1_match, // active channel 1 compare
  output wire [15:0] ch2_match, // active channel 2 compare
  output wire update_strobe, // buffers loaded, pulse
  output wire wrap_flag, // overflow or underflow, pulse
  output wire restart_pulse, // restart command, pulse
  output wire hard_reset_pulse, // hard reset command, pulse
  output wire [2:0] pin_level, // level presented to pins
  output wire [2:0] pin_override // pin taken over by waveform
);
  integer i;
  // ==========================================
  // state
  reg enable_reg;
  reg [2:0] wave_mode_reg;
  reg auto_hold_reg;
  reg [2:0] pin_en_reg;
  reg [2:0] force_reg;
  reg split_reg;
  reg hold_reg;
  reg hold_next;
  reg down_reg;
  reg down_next;
  reg [3:0] bv_reg;
  reg [3:0] bv_next;
  reg [15:0] cycle_length_reg;
  reg [15:0] cycle_length_buffer_reg;
  reg [15:0] ch_match_reg [0:2];
  reg [15:0] channel_buffer_reg [0:2];
  reg upd_reg;
  reg wrap_reg;
  reg restart_reg;
  reg hreset_reg;
  // bus state
  reg aw_held_reg;
  reg [7:0] aw_addr_reg;
  reg w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rd_word;
  // ==========================================
  // decode helpers
  function mapped;
    input [5:0] idx;
    begin
      case (idx)
        `IDX_RUN_CTRL, `IDX_MODE_CTRL, `IDX_OUT_FORCE, `IDX_SPLIT_SEL,
        `IDX_E_CLR, `IDX_E_SET, `IDX_F_CLR, `IDX_F_SET,
        `IDX_CYC_LEN, `IDX_CH0, `IDX_CH1, `IDX_CH2,
        `IDX_CYC_BUF, `IDX_CH0_BUF, `IDX_CH1_BUF, `IDX_CH2_BUF: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction
  // write side is executed once address and data are both held
  wire wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire [5:0] wr_idx = aw_addr_reg[7:2];
  wire lane0 = wr_go & w_strb_reg[0];
  wire lane1 = wr_go & w_strb_reg[1];
  wire [7:0] wd = w_data_reg[7:0];
  wire wr_eclr = lane0 & (wr_idx == `IDX_E_CLR);
  wire wr_eset = lane0 & (wr_idx == `IDX_E_SET);
  wire wr_mode = lane0 & (wr_idx == `IDX_MODE_CTRL);
  wire [1:0] e_clr = wr_eclr ? wd[1:0] : 2'h0;
  wire [1:0] e_set = wr_eset ? wd[1:0] : 2'h0;
  wire [1:0] cmd = (wr_eclr | wr_eset) ? wd[`E_CMD_MSB:`E_CMD_LSB] : `CMD_NONE;
  wire [3:0] f_clr = (lane0 & (wr_idx == `IDX_F_CLR)) ? wd[3:0] : 4'h0;
  wire [3:0] f_set = (lane0 & (wr_idx == `IDX_F_SET)) ? wd[3:0] : 4'h0;
  wire buf_lane = lane0 | lane1;
  wire [3:0] buf_wr = {buf_lane & (wr_idx == `IDX_CH2_BUF),
                       buf_lane & (wr_idx == `IDX_CH1_BUF),
                       buf_lane & (wr_idx == `IDX_CH0_BUF),
                       buf_lane & (wr_idx == `IDX_CYC_BUF)};
  // ==========================================
  // mode decode: load point and wrap point
  wire m_normal = (wave_mode_reg == `WM_NORMAL);
  wire m_freq = (wave_mode_reg == `WM_FREQ);
  wire m_one = (wave_mode_reg == `WM_ONE_RAMP);
  wire m_high = (wave_mode_reg == `WM_TWO_HIGH);
  wire m_both = (wave_mode_reg == `WM_TWO_BOTH);
  wire m_low = (wave_mode_reg == `WM_TWO_LOW);
  wire load_at_top = m_normal | m_freq;
  wire load_at_bottom = m_one | m_high | m_both | m_low;
  wire wrap_at_top = m_normal | m_freq | m_high | m_both;
  wire wrap_at_bottom = m_one | m_both | m_low;
  wire cmd_update = (cmd == `CMD_UPDATE);
  wire upd_event = (top_hit & load_at_top) | (bottom_hit & load_at_bottom) | cmd_update;
  wire transfer = upd_event & ~hold_reg;
  wire all_valid = &(bv_reg[3:1] | ~pin_en_reg);
  // ==========================================
  // next values of hold, direction and valid bits
  always @* begin
    hold_next = hold_reg;
    if (e_clr[`E_HOLD_BIT])
      hold_next = 1'b0;
    if (e_set[`E_HOLD_BIT])
      hold_next = 1'b1;
    // turning auto hold on locks the buffers until the enabled channels are written
    if (wr_mode & wd[`AUTO_HOLD_BIT] & ~auto_hold_reg)
      hold_next = 1'b1;
    if (auto_hold_reg) begin
      if (transfer)
        hold_next = 1'b1;
      else if (hold_reg & all_valid)
        hold_next = 1'b0;
    end
    down_next = down_reg;
    if (hw_dir_load)
      down_next = hw_dir_value;
    if (e_clr[`E_DIR_BIT])
      down_next = 1'b0;
    if (e_set[`E_DIR_BIT])
      down_next = 1'b1;
    // a buffer write in the update cycle keeps its valid bit
    bv_next = (transfer ? 4'h0 : (bv_reg & ~f_clr)) | f_set | buf_wr;
  end
  // ==========================================
  // control registers and buffers
  always @(posedge sys_clk) begin
    if (!resetn) begin
      enable_reg <= 1'b0;
      wave_mode_reg <= `WM_NORMAL;
      auto_hold_reg <= 1'b0;
      pin_en_reg <= 3'h0;
      force_reg <= 3'h0;
      split_reg <= 1'b0;
      hold_reg <= 1'b0;
      down_reg <= 1'b0;
      bv_reg <= 4'h0;
      cycle_length_reg <= `RST_CYC_LEN;
      cycle_length_buffer_reg <= `RST_CYC_LEN;
      for (i = 0; i < 3; i = i + 1) begin
        ch_match_reg[i] <= `RST_CH;
        channel_buffer_reg[i] <= `RST_CH;
      end
      upd_reg <= 1'b0;
      wrap_reg <= 1'b0;
      restart_reg <= 1'b0;
      hreset_reg <= 1'b0;
    end else begin
      if (lane0 & (wr_idx == `IDX_RUN_CTRL))
        enable_reg <= wd[`RUN_EN_BIT];
      if (lane0 & (wr_idx == `IDX_MODE_CTRL)) begin
        wave_mode_reg <= wd[`MODE_MSB:`MODE_LSB];
        auto_hold_reg <= wd[`AUTO_HOLD_BIT];
        pin_en_reg <= wd[`PIN_EN_MSB:`PIN_EN_LSB];
      end
      // force bits only take effect on the pins while stopped
      if (lane0 & (wr_idx == `IDX_OUT_FORCE))
        force_reg <= wd[2:0];
      if (lane0 & (wr_idx == `IDX_SPLIT_SEL))
        split_reg <= wd[0];
      hold_reg <= hold_next;
      down_reg <= down_next;
      bv_reg <= bv_next;
      // copy valid buffers; uses the values held before this cycle's writes
      if (transfer & bv_reg[0])
        cycle_length_reg <= cycle_length_buffer_reg;
      for (i = 0; i < 3; i = i + 1) begin
        if (transfer & bv_reg[i+1])
          ch_match_reg[i] <= channel_buffer_reg[i];
      end
      if (buf_wr[0] & lane0)
        cycle_length_buffer_reg[7:0] <= wd;
      if (buf_wr[0] & lane1)
        cycle_length_buffer_reg[15:8] <= w_data_reg[15:8];
      for (i = 0; i < 3; i = i + 1) begin
        if (buf_wr[i+1] & lane0)
          channel_buffer_reg[i][7:0] <= wd;
        if (buf_wr[i+1] & lane1)
          channel_buffer_reg[i][15:8] <= w_data_reg[15:8];
      end
      upd_reg <= transfer;
      wrap_reg <= (top_hit & wrap_at_top) | (bottom_hit & wrap_at_bottom);
      restart_reg <= (cmd == `CMD_RESTART);
      hreset_reg <= (cmd == `CMD_HARD_RESET) & ~enable_reg;
    end
  end
  // ==========================================
  // read multiplexer
  always @* begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr[7:2])
      `IDX_RUN_CTRL: rd_word[0] = enable_reg;
      `IDX_MODE_CTRL: rd_word[6:0] = {pin_en_reg, auto_hold_reg, wave_mode_reg};
      `IDX_OUT_FORCE: rd_word[2:0] = pin_level;
      `IDX_SPLIT_SEL: rd_word[0] = split_reg;
      // command bits stay zero in both views
      `IDX_E_CLR, `IDX_E_SET: rd_word[1:0] = {hold_reg, down_reg};
      `IDX_F_CLR, `IDX_F_SET: rd_word[3:0] = bv_reg;
      `IDX_CYC_LEN: rd_word[15:0] = cycle_length_reg;
      `IDX_CH0: rd_word[15:0] = ch_match_reg[0];
      `IDX_CH1: rd_word[15:0] = ch_match_reg[1];
      `IDX_CH2: rd_word[15:0] = ch_match_reg[2];
      `IDX_CYC_BUF: rd_word[15:0] = cycle_length_buffer_reg;
      `IDX_CH0_BUF: rd_word[15:0] = channel_buffer_reg[0];
      `IDX_CH1_BUF: rd_word[15:0] = channel_buffer_reg[1];
      `IDX_CH2_BUF: rd_word[15:0] = channel_buffer_reg[2];
      default: rd_word = 32'h0000_0000;
    endcase
  end
  // ==========================================
  // AXI4-Lite handshakes
  always @(posedge sys_clk) begin
    if (!resetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready)
        bvalid_reg <= 1'b0;
      if (s_axi_arvalid & s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= mapped(s_axi_araddr[7:2]) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end
  // ==========================================
  // outputs
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign timer_enable = enable_reg;
  assign waveform_mode_field = wave_mode_reg;
  assign top_from_channel0 = m_freq;
  assign split_select_bit = split_reg;
  assign count_down = down_reg;
  assign buffer_load_hold = hold_reg;
  assign buffer_valid = bv_reg;
  assign cycle_length_out = cycle_length_reg;
  assign ch0_match = ch_match_reg[0];
  assign ch1_match = ch_match_reg[1];
  assign ch2_match = ch_match_reg[2];
  assign update_strobe = upd_reg;
  assign wrap_flag = wrap_reg;
  assign restart_pulse = restart_reg;
  assign hard_reset_pulse = hreset_reg;
  // stopped timer shows forced levels, running one the generator
  assign pin_level = enable_reg ? wave_level_in : force_reg;
  // waveform takes over a pin only while running, outside normal mode and with its pin enable
  assign pin_override = (m_normal | ~enable_reg) ? 3'h0 : pin_en_reg;
endmodule // timer_mode_control_regs
`default_nettype wire

// ==== verif/timer_ctrl_assertions.sv ====
// checker for the timer mode and control block
// assumes it is bound onto the top module and sees its ports only
`timescale 1ns/10ps
`default_nettype none
module timer_ctrl_checker (
  input wire sys_clk, // clock
  input wire resetn, // sync reset, low
  input wire s_axi_awready, // high: no write executing
  input wire top_hit, // top pulse
  input wire bottom_hit, // bottom pulse
  input wire hw_dir_load, // hw direction load
  input wire hw_dir_value, // hw direction value
  input wire [2:0] wave_level_in, // generator levels
  input wire timer_enable, // run enable
  input wire [2:0] waveform_mode_field, // mode
  input wire top_from_channel0, // top source
  input wire count_down, // direction
  input wire buffer_load_hold, // lock
  input wire [3:0] buffer_valid, // valid bits
  input wire [15:0] cycle_length_out, // active length
  input wire wrap_flag, // wrap pulse
  input wire hard_reset_pulse, // hard reset pulse
  input wire [2:0] pin_level, // pin levels
  input wire [2:0] pin_override // pin takeover
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // mode masks: wrap at top, wrap at bottom, load at top, load at bottom
  wire [7:0] tw = 8'h63;
  wire [7:0] bw = 8'hC8;
  wire [7:0] tu = 8'h03;
  wire [7:0] bu = 8'hE8;
  wire [2:0] m = waveform_mode_field;
  wire at_wrap = (top_hit & tw[m]) | (bottom_hit & bw[m]);
  wire at_upd = (top_hit & tu[m]) | (bottom_hit & bu[m]);
  sequence s_locked_upd;
    at_upd && buffer_load_hold && s_axi_awready;
  endsequence
  sequence s_free_upd;
    top_hit && m == 3'h0 && !buffer_load_hold && s_axi_awready;
  endsequence
  // ==========================================
  // properties
  AST_TOP_SRC: assert property (top_from_channel0 == (m == 3'h1))
    else $error("top source wrong");
  AST_WRAP_SET: assert property (at_wrap |=> wrap_flag)
    else $error("wrap missing");
  AST_WRAP_ONLY: assert property (wrap_flag |-> $past(at_wrap))
    else $error("wrap without cause");
  AST_HOLD_KEEP: assert property (s_locked_upd |=>
    $stable(buffer_valid) && $stable(cycle_length_out))
    else $error("locked update loaded");
  AST_FREE_UPD: assert property (s_free_upd |=> buffer_valid == 4'h0)
    else $error("valid not cleared");
  AST_DIR_HW: assert property (hw_dir_load && s_axi_awready |=>
    count_down == $past(hw_dir_value))
    else $error("direction not loaded");
  AST_HARD_RST: assert property (hard_reset_pulse |-> !$past(timer_enable))
    else $error("hard reset while enabled");
  AST_PIN_RUN: assert property (timer_enable |-> pin_level == wave_level_in)
    else $error("pin level wrong");
  AST_PIN_NORM: assert property (m == 3'h0 || !timer_enable |-> pin_override == 3'h0)
    else $error("pin taken in normal mode");
endmodule // timer_ctrl_checker
bind timer_mode_control_regs timer_ctrl_checker chk_u (.sys_clk, .resetn, .s_axi_awready,
  .top_hit, .bottom_hit, .hw_dir_load, .hw_dir_value, .wave_level_in, .timer_enable,
  .waveform_mode_field, .top_from_channel0, .count_down, .buffer_load_hold, .buffer_valid,
  .cycle_length_out, .wrap_flag, .hard_reset_pulse, .pin_level, .pin_override);
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the timer mode and control block
// assumes the design header is on the include path
`timescale 1ns/10ps
`include "timer_ctrl_map.vh"
`default_nettype none
`define CHK(n, e, g) checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end
module tb;
  reg sys_clk = 1'b0, resetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg top_hit = 1'b0, bottom_hit = 1'b0, hw_dir_load = 1'b0, hw_dir_value = 1'b0;
  reg [2:0] wave_level_in = 3'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire timer_enable, top_from_channel0, split_select_bit, count_down, buffer_load_hold;
  wire update_strobe, wrap_flag, restart_pulse, hard_reset_pulse;
  wire [2:0] waveform_mode_field, pin_level, pin_override;
  wire [3:0] buffer_valid;
  wire [15:0] cycle_length_out, ch0_match, ch1_match, ch2_match;
  integer num_errors = 0, checks_done = 0, i;
  reg hr_seen = 1'b0, rs_seen = 1'b0, hr_idle_seen = 1'b0;
  reg [33:0] rows [0:9];
  reg [7:0] wa, wd, ra, ed;
  reg [1:0] er, rsp;
  reg [31:0] rd;
  localparam [7:0] TMASK = 8'h63;
  localparam [7:0] BMASK = 8'hC8;
  localparam [7:0] UTMASK = 8'h03;
  localparam [7:0] UBMASK = 8'hE8;
  timer_mode_control_regs dut_u (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .top_hit, .bottom_hit,
    .hw_dir_load, .hw_dir_value, .wave_level_in, .timer_enable, .waveform_mode_field,
    .top_from_channel0, .split_select_bit, .count_down, .buffer_load_hold, .buffer_valid,
    .cycle_length_out, .ch0_match, .ch1_match, .ch2_match, .update_strobe, .wrap_flag,
    .restart_pulse, .hard_reset_pulse, .pin_level, .pin_override);
  // ==========================================
  // clock, sticky record of command pulses, hard reset split by run state, restart at any time
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (hard_reset_pulse && timer_enable) hr_seen <= 1'b1;
    if (hard_reset_pulse && !timer_enable) hr_idle_seen <= 1'b1;
    if (restart_pulse) rs_seen <= 1'b1;
  end
  // ==========================================
  // bus tasks: hold each channel until its ready is seen at an edge
  task axi_wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    reg aw, w, dn;
    begin
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      dn = 1'b0;
      while (!dn) begin
        @(negedge sys_clk);
        aw = s_axi_awvalid & s_axi_awready;
        w = s_axi_wvalid & s_axi_wready;
        dn = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge sys_clk);
        if (aw) s_axi_awvalid <= 1'b0;
        if (w) s_axi_wvalid <= 1'b0;
        if (dn) s_axi_bready <= 1'b0;
      end
      @(negedge sys_clk);
    end
  endtask
  task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg ta, dn;
    begin
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      dn = 1'b0;
      while (!dn) begin
        @(negedge sys_clk);
        ta = s_axi_arvalid & s_axi_arready;
        dn = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge sys_clk);
        if (ta) s_axi_arvalid <= 1'b0;
        if (dn) s_axi_rready <= 1'b0;
      end
      @(negedge sys_clk);
    end
  endtask
  task w8(input [7:0] a, input [7:0] d);
    axi_wr(a, {24'h0, d}, 4'hF, rsp);
  endtask
  // one-cycle top or bottom hit, then settle
  task hit(input t, input b);
    begin
      @(posedge sys_clk);
      top_hit <= t;
      bottom_hit <= b;
      @(posedge sys_clk);
      top_hit <= 1'b0;
      bottom_hit <= 1'b0;
      @(negedge sys_clk);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ==========================================
  // watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    print_verdict;
  end
  // ==========================================
  // main sequence: rows {write addr, data, read addr, expected, response}
  initial begin
    rows[0] = {8'h08, 8'hFF, 8'h08, 8'h07, 2'h0};
    rows[1] = {8'h0C, 8'h01, 8'h0C, 8'h01, 2'h0};
    rows[2] = {8'h14, 8'h0F, 8'h10, 8'h03, 2'h0};
    rows[3] = {8'h10, 8'h01, 8'h14, 8'h02, 2'h0};
    rows[4] = {8'h10, 8'h02, 8'h14, 8'h00, 2'h0};
    rows[5] = {8'h1C, 8'h0F, 8'h18, 8'h0F, 2'h0};
    rows[6] = {8'h18, 8'h05, 8'h1C, 8'h0A, 2'h0};
    rows[7] = {8'h18, 8'h0A, 8'h18, 8'h00, 2'h0};
    rows[8] = {8'h04, 8'h07, 8'h04, 8'h07, 2'h0};
    rows[9] = {8'h20, 8'h5A, 8'h20, 8'h00, `RESP_SLVERR};
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    for (i = 0; i < 10; i++) begin
      {wa, wd, ra, ed, er} = rows[i];
      axi_wr(wa, {24'h0, wd}, 4'hF, rsp);
      `CHK("bresp", er, rsp);
      axi_rd(ra, rd, rsp);
      `CHK("rdata", {24'h0, ed}, rd);
      `CHK("rresp", er, rsp);
    end
    `CHK("hard reset idle", 1'b1, hr_idle_seen);
    $display("row test done");
    // reset in mid-run
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    axi_rd(8'h98, rd, rsp);
    `CHK("length reset", {16'h0, `RST_CYC_LEN}, rd);
    `CHK("split reset", 1'b0, split_select_bit);
    `CHK("mode reset", 3'h0, waveform_mode_field);
    $display("reset test done");
    // wrap point of every mode code
    for (i = 0; i < 8; i++) begin
      w8(8'h04, i[7:0]);
      `CHK("mode", i[2:0], waveform_mode_field);
      hit(1'b1, 1'b0);
      `CHK("wrap top", TMASK[i], wrap_flag);
      `CHK("update top", UTMASK[i], update_strobe);
      hit(1'b0, 1'b1);
      `CHK("wrap bottom", BMASK[i], wrap_flag);
      `CHK("update bottom", UBMASK[i], update_strobe);
      `CHK("top source", i == 1, top_from_channel0);
    end
    $display("mode test done");
    // buffered loads, hold, command update, byte strobe
    w8(8'h04, 8'h00);
    axi_wr(8'hD8, 32'h1234, 4'hF, rsp);
    `CHK("valid", 4'h1, buffer_valid);
    axi_wr(8'hE0, 32'h00AB, 4'hF, rsp);
    `CHK("valid", 4'h3, buffer_valid);
    w8(8'h14, 8'h02);
    hit(1'b1, 1'b0);
    `CHK("held valid", 4'h3, buffer_valid);
    `CHK("held length", `RST_CYC_LEN, cycle_length_out);
    w8(8'h10, 8'h02);
    hit(1'b1, 1'b0);
    `CHK("valid", 4'h0, buffer_valid);
    `CHK("length", 16'h1234, cycle_length_out);
    `CHK("ch0", 16'h00AB, ch0_match);
    axi_wr(8'hD8, 32'hFF56, 4'h1, rsp);
    w8(8'h14, 8'h04);
    `CHK("cmd update", 16'h1256, cycle_length_out);
    axi_wr(8'hE8, 32'hBEEF, 4'h3, rsp);
    axi_wr(8'hF0, 32'hCAFE, 4'h2, rsp);
    `CHK("valid", 4'hC, buffer_valid);
    w8(8'h14, 8'h04);
    `CHK("ch1", 16'hBEEF, ch1_match);
    `CHK("ch2", 16'hCA00, ch2_match);
    $display("update test done");
    // running: commands, pin levels and takeover
    @(posedge sys_clk);
    wave_level_in <= 3'h5;
    w8(8'h00, 8'h01);
    `CHK("enable", 1'b1, timer_enable);
    w8(8'h14, 8'h0C);
    w8(8'h14, 8'h08);
    `CHK("hard reset", 1'b0, hr_seen);
    `CHK("restart", 1'b1, rs_seen);
    `CHK("pin level", 3'h5, pin_level);
    w8(8'h04, 8'h73);
    `CHK("override", 3'h7, pin_override);
    w8(8'h04, 8'h70);
    `CHK("override", 3'h0, pin_override);
    // auto hold with channel zero enabled; turning it on must lock by itself
    `CHK("hold before auto", 1'b0, buffer_load_hold);
    w8(8'h04, 8'h18);
    `CHK("auto hold", 1'b1, buffer_load_hold);
    axi_wr(8'hE0, 32'h0011, 4'hF, rsp);
    `CHK("auto release", 1'b0, buffer_load_hold);
    hit(1'b1, 1'b0);
    `CHK("auto rehold", 1'b1, buffer_load_hold);
    `CHK("ch0", 16'h0011, ch0_match);
    // hardware direction load
    @(posedge sys_clk);
    hw_dir_load <= 1'b1;
    hw_dir_value <= 1'b1;
    @(posedge sys_clk);
    hw_dir_load <= 1'b0;
    @(negedge sys_clk);
    `CHK("count down", 1'b1, count_down);
    $display("control test done");
    print_verdict;
  end
endmodule // tb
`default_nettype wire
